// File: fsp_pkg.sv
package fsp_pkg;

    // Register byte offsets
    localparam logic [7:0] CTL_OFS = 8'h00;
    localparam logic [7:0] ZPTR_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS = 8'h08;
    localparam logic [7:0] CMD_OFS = 8'h0c;
    localparam logic [7:0] RESULT_OFS = 8'h10;
    localparam logic [7:0] LOCK_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;

    // self_prog_control_reg fields
    localparam int CTL_ENABLE = 0;
    localparam int CTL_ERASE = 1;
    localparam int CTL_WRITE = 2;
    localparam int CTL_LOCK_SET = 3;
    localparam int CTL_REENABLE = 4;
    localparam int CTL_SIG_READ = 5;
    localparam int CTL_RWW_BUSY = 6;
    localparam int CTL_IRQ_EN = 7;
    localparam logic [7:0] CTL_RST = 8'h00;

    // Command register strobes
    localparam int CMD_STORE = 0;
    localparam int CMD_LOAD = 1;

    // Command selector, control bits 5..1
    localparam logic [4:0] SEL_LOAD_BUF = 5'h00;
    localparam logic [4:0] SEL_ERASE = 5'h01;
    localparam logic [4:0] SEL_WRITE = 5'h02;
    localparam logic [4:0] SEL_LOCK = 5'h04;
    localparam logic [4:0] SEL_REENABLE = 5'h08;

    // Z pointer layout: byte select, word in page, page index
    localparam int Z_WORD_LSB = 1;
    localparam int Z_PAGE_LSB = 7;

    // Command windows in clock cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;

    // Special read addresses
    localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
    localparam logic [15:0] Z_LOCK = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam logic [4:0] SIG_DEV1 = 5'h00;
    localparam logic [4:0] SIG_CAL = 5'h01;
    localparam logic [4:0] SIG_DEV2 = 5'h02;
    localparam logic [4:0] SIG_DEV3 = 5'h04;
    localparam logic [4:0] SIG_SERIAL_FIRST = 5'h0e;
    localparam logic [4:0] SIG_SERIAL_LAST = 5'h18;
    localparam int LOCK_LSB = 2;
    localparam int LOCK_MSB = 5;
    localparam int FUSE_EXT_BITS = 3;
    localparam logic [7:0] LOCK_RST = 8'hff;
    localparam logic [7:0] UNPROG_BYTE = 8'hff;

    // Programming time
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PROG_MIN_NS = 3700000;
    // Wide product, the time in picoseconds does not fit an int
    localparam int PROG_CYCLES_DFLT = int'(
        (longint'(PROG_MIN_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_ERASE,
        OP_WRITE,
        OP_LOCK
    } fsp_op_type;

endpackage

// File: fsp_op_timer.sv
module fsp_op_timer
    import fsp_pkg::*;
#(
    parameter int CYCLES = PROG_CYCLES_DFLT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic busy_q,
    output logic done_q
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q <= '0;
            end else if (busy_q) begin
                if (cnt_q == LAST) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

endmodule

// File: fsp_page_buf.sv
module fsp_page_buf #(
    parameter int WORD_BITS = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clr,
    input wire logic wr,
    input wire logic [WORD_BITS-1:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [WORD_BITS-1:0] raddr,
    output logic [15:0] rdata_q,
    output logic any_loaded_q
);
    localparam int WORDS = 1 << WORD_BITS;

    logic [15:0] mem [WORDS];
    logic [WORDS-1:0] loaded_q;

    // Only the loaded flags need reset; data of unloaded words is masked
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            loaded_q <= '0;
        end else if (wr && !loaded_q[waddr]) begin
            loaded_q[waddr] <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (wr && !loaded_q[waddr]) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= 16'hffff;
            any_loaded_q <= 1'b0;
        end else begin
            rdata_q <= loaded_q[raddr] ? mem[raddr] : 16'hffff;
            any_loaded_q <= |loaded_q;
        end
    end

endmodule

// File: fsp_ctrl.sv
// Functional notes
// - Erase pattern then store within four cycles
// - Erasing no-read-while-write page halts CPU
// - Load pattern stores data word at word index
// - Buffer cleared by write, re-enable, reset
// - EEPROM write mid-load discards buffered data
// - Write pattern then store within four cycles
// - Writing no-read-while-write page halts CPU
// - Target page latched at operation start
// - Interrupt is level while enable bit clear
// - Erase or write blocks section, sets busy
// - Busy holds until re-enable bit is written
// - Cleared data bits 5..2 program lock bits
// - Lock programming keeps all flash readable
// - EEPROM write blocks stores and fuse reads, not signature loads
// - Z 0x0001 lock-set load returns lock byte
// - Lock-set and enable clear on read/timeout
// - Fuse bytes at Z 0, 3 and 2
// - Programmed bits read zero, others one
// - Signature read returns row byte at Z
// - Signature bytes at 0,2,4; calibration at 1
// - Ten-byte serial number from 0x0E up
// - Loads use Z bit 0 as byte select
module fsp_ctrl
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT,
    parameter int WORD_BITS = 6,
    parameter int PAGE_BITS = 6,
    parameter int NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 32,
    parameter logic [7:0] SIG_BYTE1 = 8'h5a, // Arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h11, // Arbitrary value
    parameter logic [7:0] SIG_BYTE3 = 8'h22, // Arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80,
    parameter logic [7:0] SERIAL_SEED = 8'h3c // Arbitrary value
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic eeprom_write_busy_bit,
    input wire logic [7:0] fuse_low_byte,
    input wire logic [7:0] fuse_high_byte,
    input wire logic [7:0] fuse_extended_byte,
    input wire logic [WORD_BITS-1:0] flash_buf_raddr,
    output logic [15:0] flash_buf_rdata_q,
    output logic flash_erase_q,
    output logic flash_write_q,
    output logic [PAGE_BITS-1:0] flash_page_q,
    output logic [7:0] lock_bits_q,
    output logic cpu_halt_q,
    output logic rww_read_block_q,
    output logic spm_irq_q
);
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    logic aw_full_q, w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic [7:0] ctl_q;
    logic [15:0] zptr_q;
    logic [15:0] data_q;
    logic [2:0] store_win_q, load_win_q;
    logic store_cmd, load_cmd, wr_ctl;
    logic store_go, load_go;
    logic ee_busy_q;
    fsp_op_type op_q;
    logic timer_start, timer_busy, timer_done;
    logic rww_busy_q;
    logic [3:0] lock_data_q;
    logic [8:0] result_q;
    logic buf_clr, buf_wr, buf_loaded;
    logic [PAGE_BITS-1:0] z_page;
    logic op_busy;
    logic [7:0] special_byte;

    assign z_page = zptr_q[Z_PAGE_LSB +: PAGE_BITS];
    assign op_busy = (op_q != OP_IDLE);

    // Bus write side: address and data taken in either order
    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            s_axi_awready <= !aw_full_q && !s_axi_awready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
            s_axi_wready <= !w_full_q && !s_axi_wready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_q)
                CTL_OFS, ZPTR_OFS, DATA_OFS, CMD_OFS:
                    s_axi_bresp <= RESP_OK;
                default: s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign wr_ctl = wr_fire && aw_addr_q == CTL_OFS && w_strb_q[0];
    assign store_cmd = wr_fire && aw_addr_q == CMD_OFS && w_strb_q[0]
        && w_data_q[CMD_STORE];
    assign load_cmd = wr_fire && aw_addr_q == CMD_OFS && w_strb_q[0]
        && w_data_q[CMD_LOAD];

    // Pointer and data registers stand in for Z and R1:R0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zptr_q <= 16'h0000;
            data_q <= 16'h0000;
        end else if (wr_fire) begin
            if (aw_addr_q == ZPTR_OFS) begin
                if (w_strb_q[0]) zptr_q[7:0] <= w_data_q[7:0];
                if (w_strb_q[1]) zptr_q[15:8] <= w_data_q[15:8];
            end
            if (aw_addr_q == DATA_OFS) begin
                if (w_strb_q[0]) data_q[7:0] <= w_data_q[7:0];
                if (w_strb_q[1]) data_q[15:8] <= w_data_q[15:8];
            end
        end
    end

    // The EEPROM controller shares this clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ee_busy_q <= 1'b0;
        end else begin
            ee_busy_q <= eeprom_write_busy_bit;
        end
    end

    assign store_go = store_cmd && ctl_q[CTL_ENABLE]
        && store_win_q != 3'h0 && !op_busy
        && !eeprom_write_busy_bit;
    assign load_go = load_cmd && ctl_q[CTL_ENABLE]
        && load_win_q != 3'h0 && !op_busy
        && (ctl_q[CTL_LOCK_SET] || ctl_q[CTL_SIG_READ]);

    // Control register, command windows and auto-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= CTL_RST;
            store_win_q <= 3'h0;
            load_win_q <= 3'h0;
        end else begin
            if (store_win_q != 3'h0) store_win_q <= store_win_q - 3'h1;
            if (load_win_q != 3'h0) load_win_q <= load_win_q - 3'h1;
            if (!op_busy && ctl_q[CTL_ENABLE] && store_win_q <= 3'h1
                    && load_win_q <= 3'h1) begin
                ctl_q[5:0] <= 6'h00;
            end
            if (store_go || load_go) begin
                store_win_q <= 3'h0;
                load_win_q <= 3'h0;
                if (!timer_start) begin
                    ctl_q[5:0] <= 6'h00;
                end
            end
            if (timer_done) begin
                ctl_q[5:0] <= 6'h00;
            end
            if (wr_ctl) begin
                ctl_q[CTL_IRQ_EN] <= w_data_q[CTL_IRQ_EN];
                if (!op_busy && !eeprom_write_busy_bit) begin
                    ctl_q[5:0] <= w_data_q[5:0];
                    store_win_q <= w_data_q[CTL_ENABLE]
                        ? STORE_WINDOW : 3'h0;
                    load_win_q <= (w_data_q[CTL_ENABLE]
                        && (w_data_q[CTL_LOCK_SET]
                        || w_data_q[CTL_SIG_READ]))
                        ? LOAD_WINDOW : 3'h0;
                end
            end
        end
    end

    // Operations that take programming time, stored before the last window cycle, keep enable set
    assign timer_start = store_go
        && (ctl_q[5:1] == SEL_ERASE
        || ctl_q[5:1] == SEL_WRITE
        || ctl_q[5:1] == SEL_LOCK);

    fsp_op_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(timer_start),
        .busy_q(timer_busy),
        .done_q(timer_done)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_q <= OP_IDLE;
            flash_page_q <= '0;
            lock_data_q <= 4'hf;
            flash_erase_q <= 1'b0;
            flash_write_q <= 1'b0;
        end else begin
            flash_erase_q <= 1'b0;
            flash_write_q <= 1'b0;
            unique case (op_q)
                OP_IDLE: begin
                    if (timer_start) begin
                        flash_page_q <= z_page;
                        lock_data_q <= data_q[LOCK_MSB:LOCK_LSB];
                        if (ctl_q[5:1] == SEL_ERASE) begin
                            op_q <= OP_ERASE;
                            flash_erase_q <= 1'b1;
                        end else if (ctl_q[5:1] == SEL_WRITE) begin
                            op_q <= OP_WRITE;
                            flash_write_q <= 1'b1;
                        end else begin
                            op_q <= OP_LOCK;
                        end
                    end
                end
                OP_ERASE, OP_WRITE, OP_LOCK: begin
                    if (timer_done) op_q <= OP_IDLE;
                end
            endcase
        end
    end

    // Lock bits only go from unprogrammed to programmed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_bits_q <= LOCK_RST;
        end else if (timer_done && op_q == OP_LOCK) begin
            lock_bits_q[LOCK_MSB:LOCK_LSB] <=
                lock_bits_q[LOCK_MSB:LOCK_LSB] & lock_data_q;
        end
    end

    // Busy and read block persist past completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rww_busy_q <= 1'b0;
            rww_read_block_q <= 1'b0;
            cpu_halt_q <= 1'b0;
        end else begin
            if (timer_start && ctl_q[5:1] != SEL_LOCK) begin
                rww_busy_q <= 1'b1;
                rww_read_block_q <= 1'b1;
                cpu_halt_q <= z_page >= PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
            end else if (timer_done) begin
                cpu_halt_q <= 1'b0;
            end else if (store_go && ctl_q[5:1] == SEL_REENABLE) begin
                rww_busy_q <= 1'b0;
                rww_read_block_q <= 1'b0;
            end
        end
    end

    // Buffer cleared on write end, re-enable, and EEPROM write start
    assign buf_clr = (timer_done && op_q == OP_WRITE)
        || (store_go && ctl_q[5:1] == SEL_REENABLE)
        || (eeprom_write_busy_bit && !ee_busy_q && buf_loaded);
    assign buf_wr = store_go && ctl_q[5:1] == SEL_LOAD_BUF;

    fsp_page_buf #(
        .WORD_BITS(WORD_BITS)
    ) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(buf_clr),
        .wr(buf_wr),
        .waddr(zptr_q[Z_WORD_LSB +: WORD_BITS]),
        .wdata(data_q),
        .raddr(flash_buf_raddr),
        .rdata_q(flash_buf_rdata_q),
        .any_loaded_q(buf_loaded)
    );

    // Special read data; bit 0 of Z selects the byte
    always_comb begin
        special_byte = UNPROG_BYTE;
        if (ctl_q[CTL_LOCK_SET]) begin
            case (zptr_q)
                Z_FUSE_LOW: special_byte = fuse_low_byte;
                Z_LOCK: special_byte = lock_bits_q;
                Z_FUSE_EXT: special_byte = {
                    {(8 - FUSE_EXT_BITS){1'b1}},
                    fuse_extended_byte[FUSE_EXT_BITS-1:0]};
                Z_FUSE_HIGH: special_byte = fuse_high_byte;
                default: special_byte = UNPROG_BYTE;
            endcase
        end else if (zptr_q[15:5] == 11'h000) begin
            if (zptr_q[4:0] == SIG_DEV1) begin
                special_byte = SIG_BYTE1;
            end else if (zptr_q[4:0] == SIG_CAL) begin
                special_byte = CAL_BYTE;
            end else if (zptr_q[4:0] == SIG_DEV2) begin
                special_byte = SIG_BYTE2;
            end else if (zptr_q[4:0] == SIG_DEV3) begin
                special_byte = SIG_BYTE3;
            end else if (zptr_q[4:0] >= SIG_SERIAL_FIRST
                    && zptr_q[4:0] < SIG_SERIAL_LAST) begin
                special_byte = SERIAL_SEED ^ {3'h0, zptr_q[4:0]};
            end
        end
    end

    // Bit 8 marks that the load was served here, not by the flash
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_q <= 9'h000;
        end else if (load_cmd) begin
            if (load_go && !(ctl_q[CTL_LOCK_SET]
                    && eeprom_write_busy_bit)) begin
                result_q <= {1'b1, special_byte};
            end else begin
                result_q <= 9'h000;
            end
        end
    end

    // Level, not pulse, so software may wait on it in place of polling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spm_irq_q <= 1'b0;
        end else begin
            spm_irq_q <= ctl_q[CTL_IRQ_EN] && !ctl_q[CTL_ENABLE];
        end
    end

    // Bus read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OK;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OK;
                case (s_axi_araddr)
                    CTL_OFS: s_axi_rdata <= {24'h0, ctl_q[7],
                        rww_busy_q, ctl_q[5:0]};
                    ZPTR_OFS: s_axi_rdata <= {16'h0, zptr_q};
                    DATA_OFS: s_axi_rdata <= {16'h0, data_q};
                    CMD_OFS: s_axi_rdata <= 32'h0;
                    RESULT_OFS: s_axi_rdata <= {23'h0, result_q};
                    LOCK_OFS: s_axi_rdata <= {24'h0, lock_bits_q};
                    STATUS_OFS: s_axi_rdata <= {27'h0, buf_loaded,
                        ee_busy_q, cpu_halt_q, timer_busy, op_busy};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// File: fsp_ctrl_props.sv
module fsp_ctrl_props #(
    parameter int PAGE_BITS = 6,
    parameter int NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic flash_erase_q,
    input wire logic flash_write_q,
    input wire logic [PAGE_BITS-1:0] flash_page_q,
    input wire logic [7:0] lock_bits_q,
    input wire logic cpu_halt_q,
    input wire logic rww_read_block_q,
    input wire logic spm_irq_q
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence op_start;
        flash_erase_q || flash_write_q;
    endsequence
    sequence high_start;
        op_start ##0 (flash_page_q >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
    endsequence
    sequence low_start;
        op_start ##0 (flash_page_q < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
    endsequence

    pulse_once_a:
        assert property (op_start |=> !(flash_erase_q || flash_write_q))
        else $error("start pulse too long");
    high_halt_a:
        assert property (high_start |=> cpu_halt_q [*8])
        else $error("cpu not halted");
    low_run_a:
        assert property (low_start |=> !cpu_halt_q [*8])
        else $error("cpu halted on low page");
    page_latch_a:
        assert property (op_start |=> $stable(flash_page_q) [*8])
        else $error("page moved during op");
    busy_block_a:
        assert property (op_start |=> rww_read_block_q [*8])
        else $error("section not blocked");
    halt_block_a:
        assert property (cpu_halt_q |-> rww_read_block_q)
        else $error("halt without block");
    irq_quiet_a:
        assert property (cpu_halt_q && $past(cpu_halt_q) |-> !spm_irq_q)
        else $error("irq during op");
    reenable_only_a:
        assert property ($fell(rww_read_block_q) && $past(aresetn)
            |-> ##[0:2] s_axi_bvalid)
        else $error("block cleared without write");
    lock_fixed_a:
        assert property ((lock_bits_q | 8'h3c) == 8'hff)
        else $error("fixed lock bit changed");
endmodule

bind fsp_ctrl fsp_ctrl_props #(
    .PAGE_BITS(PAGE_BITS),
    .NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
) props (.*);

// File: fsp_env.sv
module fsp_env #(
    parameter int EE_CYCLES = 60
) (
    input wire logic aclk,
    input wire logic ee_go,
    output logic eeprom_write_busy_bit,
    output logic [7:0] fuse_low_byte,
    output logic [7:0] fuse_high_byte,
    output logic [7:0] fuse_extended_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Programmed fuse bits are zero
    assign fuse_low_byte = 8'h5e;
    assign fuse_high_byte = 8'hd9;
    assign fuse_extended_byte = 8'hf4;
    always @(posedge aclk) begin
        cnt <= ee_go ? EE_CYCLES : (cnt > 0 ? cnt - 1 : 0);
    end
    assign eeprom_write_busy_bit = cnt != 0;
endmodule

// File: test_flash_self_program_controller.sv
module test_flash_self_program_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1;
    logic s_axi_rready = 1'h1;
    logic ee_go = 1'h0;
    logic [5:0] flash_buf_raddr = 6'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, eeprom_write_busy_bit;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, v;
    logic [15:0] flash_buf_rdata_q;
    logic flash_erase_q, flash_write_q, cpu_halt_q;
    logic rww_read_block_q, spm_irq_q;
    logic [5:0] flash_page_q;
    logic [7:0] lock_bits_q, fuse_low_byte, fuse_high_byte;
    logic [7:0] fuse_extended_byte;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    // Entries are control byte, Z and expected byte
    logic [31:0] tab [10] = '{32'h090001eb, 32'h0900005e, 32'h090003d9,
        32'h090002fc, 32'h2100005a, 32'h21000180, 32'h21000211,
        32'h21000422, 32'h21000e32, 32'h2100172b};

    fsp_ctrl #(.PROG_CYCLES(20), .SIG_BYTE1(8'h5a), .SIG_BYTE2(8'h11),
        .SIG_BYTE3(8'h22), .CAL_BYTE(8'h80), .SERIAL_SEED(8'h3c)) uut (.*);
    fsp_env env (.*);

    initial begin
        forever #2 aclk = ~aclk;
    end

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Bready stays high, so a response never waits on the bench
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // Command write follows at once, the window is only four edges for a store, three for a load
    task automatic cmd(input logic [7:0] c, input logic [1:0] s);
        wr(CTL_OFS, {24'h0, c});
        wr(CMD_OFS, {30'h0, s});
    endtask

    task automatic idle;
        for (int i = 0; i < 60; i++) begin
            rd(CTL_OFS, v);
            if (v[CTL_ENABLE] === 1'h0) break;
        end
    endtask

    task automatic buf_at(input logic [5:0] w, input logic [15:0] e);
        flash_buf_raddr <= w;
        repeat (2) @(posedge aclk);
        chk("buffer", {16'h0, e}, {16'h0, flash_buf_rdata_q});
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd(CTL_OFS, v);
        chk("ctl", {24'h0, CTL_RST}, v);
        rd(LOCK_OFS, v);
        chk("lock", {24'h0, LOCK_RST}, v);
        rd(8'h1c, v);
        chk("resp", 32'h2, {30'h0, resp});
        buf_at(6'h05, 16'hffff);
        $display("test reset done");
        wr(ZPTR_OFS, 32'h0a);
        wr(DATA_OFS, 32'h1234);
        cmd(8'h01, 2'h1);
        buf_at(6'h05, 16'h1234);
        wr(ZPTR_OFS, 32'h1403);
        cmd(8'h83, 2'h1);
        s_axi_wstrb <= 4'h2;
        wr(ZPTR_OFS, 32'h0);
        s_axi_wstrb <= 4'hf;
        chk("halt", 32'h1, 32'(cpu_halt_q));
        chk("page", 32'd40, 32'(flash_page_q));
        rd(ZPTR_OFS, v);
        chk("zptr", 32'h3, v);
        rd(CTL_OFS, v);
        chk("busy", 32'h1, 32'(v[CTL_RWW_BUSY]));
        idle();
        chk("irq", 32'h1, 32'(spm_irq_q));
        chk("block", 32'h1, 32'(rww_read_block_q));
        cmd(8'h11, 2'h1);
        chk("block", 32'h0, 32'(rww_read_block_q));
        buf_at(6'h05, 16'hffff);
        $display("test erase done");
        wr(ZPTR_OFS, 32'h4);
        wr(DATA_OFS, 32'hbeef);
        cmd(8'h01, 2'h1);
        wr(ZPTR_OFS, 32'h180);
        cmd(8'h05, 2'h1);
        chk("halt", 32'h0, 32'(cpu_halt_q));
        chk("page", 32'd3, 32'(flash_page_q));
        idle();
        buf_at(6'h02, 16'hffff);
        cmd(8'h11, 2'h1);
        $display("test write done");
        wr(DATA_OFS, 32'hffeb);
        cmd(8'h09, 2'h1);
        chk("block", 32'h0, 32'(rww_read_block_q));
        idle();
        rd(LOCK_OFS, v);
        chk("lock", 32'heb, v);
        wr(CTL_OFS, 32'h09);
        repeat (8) @(posedge aclk);
        rd(CTL_OFS, v);
        chk("ctl", 32'h0, v);
        for (int i = 0; i < 10; i++) begin
            wr(ZPTR_OFS, {16'h0, tab[i][23:8]});
            cmd(tab[i][31:24], 2'h2);
            rd(RESULT_OFS, v);
            chk("result", {23'h0, 1'h1, tab[i][7:0]}, v);
            rd(CTL_OFS, v);
            chk("ctl", 32'h0, v);
        end
        $display("test reads done");
        wr(ZPTR_OFS, 32'h0e);
        cmd(8'h01, 2'h1);
        ee_go <= 1'h1;
        @(posedge aclk);
        ee_go <= 1'h0;
        // Clear lands one edge after busy rises
        @(posedge aclk);
        buf_at(6'h07, 16'hffff);
        cmd(8'h03, 2'h1);
        rd(CTL_OFS, v);
        chk("ctl", 32'h0, v);
        chk("block", 32'h0, 32'(rww_read_block_q));
        $display("test eeprom done");
        finish_test();
    end
endmodule
